// ==== logic/hall_regs_pkg.sv ====
// package: offsets, field positions and reset values of the hall rotation register bank
// assumes: 8-bit registers addressed by an 8-bit register pointer
package hall_regs_pkg;
    localparam logic [7:0] rotation_ui_control_offset = 8'h70;
    localparam logic [7:0] hall_sense_control_offset = 8'h71;
    localparam logic [7:0] pair_a_tuning_settings_offset = 8'h72;
    localparam logic [7:0] pair_b_tuning_settings_offset = 8'h73;
    localparam logic [7:0] pair_a_compensation_low_offset = 8'h74;
    localparam logic [7:0] pair_b_compensation_low_offset = 8'h75;
    localparam logic [7:0] pair_a_multipliers_offset = 8'h76;
    localparam logic [7:0] pair_b_multipliers_offset = 8'h77;
    localparam logic [7:0] angle_sign_status_offset = 8'h78;
    localparam logic [7:0] phase_sine_constant_offset = 8'h79;
    localparam logic [7:0] phase_cosine_constant_offset = 8'h7a;
    localparam logic [7:0] rotation_ui_control_reset = 8'h0c;
    localparam logic [7:0] rotation_ui_control_mask = 8'hfd;
    localparam logic [7:0] hall_sense_control_reset = 8'h03;
    localparam logic [7:0] hall_sense_control_mask = 8'hb3;
    localparam logic [7:0] tuning_settings_reset = 8'h73;
    localparam logic [7:0] zero_reset = 8'h00;
    localparam logic [7:0] angle_status_write_mask = 8'h08;
    localparam int wheel_disable_bit = 7;
    localparam int interval_disable_bit = 6;
    localparam int zero_wheel_bit = 5;
    localparam int wheel_event_mask_bit = 4;
    localparam int interval_event_mask_bit = 3;
    localparam int auto_calibration_bit = 2;
    localparam int wheel_wakeup_bit = 0;
    localparam int channel_count_filter_bit = 7;
    localparam int direction_invert_bit = 3;
    localparam logic [5:0] target_scale_shift = 6'h05;
    localparam logic [7:0] base_75 = 8'h4b;
    localparam logic [7:0] base_100 = 8'h64;
    localparam logic [7:0] base_150 = 8'h96;
    localparam logic [7:0] base_200 = 8'hc8;
    typedef enum logic [1:0] {
        tuning_off_type_v, tuning_comp_type_v, tuning_fine_type_v, tuning_full_type_v
    } auto_tuning_mode_type;
endpackage : hall_regs_pkg

// ==== logic/pair_cfg_if.sv ====
// interface: decoded tuning settings of one hall channel pair
// assumes: driven by pair_tuning_decode, read by the register bank
`timescale 1ns/1ps
interface pair_cfg_if;
    logic [7:0] tuning_base_value;
    logic [10:0] count_target;
    logic [9:0] compensation;
    logic [1:0] coarse_multiplier;
    logic [3:0] fine_multiplier;
    modport source (output tuning_base_value, count_target, compensation,
        coarse_multiplier, fine_multiplier);
    modport sink (input tuning_base_value, count_target, compensation,
        coarse_multiplier, fine_multiplier);
endinterface : pair_cfg_if

// ==== logic/pair_tuning_decode.sv ====
// decoder: turns one pair's three register bytes into tuning values
// assumes: register bytes are stable register outputs
`timescale 1ns/1ps
module pair_tuning_decode (
    // register bytes
    input wire logic [7:0] tuning_settings,
    input wire logic [7:0] compensation_low,
    input wire logic [7:0] multipliers,
    // decoded values
    pair_cfg_if.source cfg
);
    function automatic logic [7:0] base_lookup(input logic [1:0] code);
        case (code)
            2'h0: base_lookup = hall_regs_pkg::base_75;
            2'h1: base_lookup = hall_regs_pkg::base_100;
            2'h2: base_lookup = hall_regs_pkg::base_150;
            default: base_lookup = hall_regs_pkg::base_200;
        endcase
    endfunction : base_lookup

    assign cfg.tuning_base_value = base_lookup(tuning_settings[7:6]);
    assign cfg.count_target = {tuning_settings[5:0], 5'h00};
    assign cfg.compensation = {multipliers[7:6], compensation_low};
    assign cfg.coarse_multiplier = multipliers[5:4];
    assign cfg.fine_multiplier = multipliers[3:0];
endmodule : pair_tuning_decode

// ==== logic/hall_rotation_config_regs.sv ====
// register bank for hall rotation sensing configuration and angle status
// assumes: the serial slave delivers one-cycle write/read strobes with a register pointer
// Contract
// - bit 7 of ui control disables wheel angle processing when one.
// - bit 6 of ui control disables interval output when one.
// - writing one to bit 5 zeroes the wheel; hardware clears it when done.
// - bit 4 masks wheel events, bit 3 interval events; reset masks interval only.
// - bit 2 enables continuous auto calibration; set after reset.
// - bit 0 enables wheel wake-up on channel zero touch.
// - sensor settings bit 7 enables per-channel count filter.
// - bits 5-4 choose sampling divider 1/2, 1/4, 1/8, 1/16.
// - bits 1-0 choose auto tuning mode off, comp, comp+fine, full.
// - tuning bits 7-6 select base value 75, 100, 150 or 200.
// - tuning bits 5-0 are a target multiplied by 32.
// - separate tuning registers for channel pairs two/three and four/five.
// - ten-bit compensation: low byte plus multipliers bits 7-6.
// - multipliers bits 5-4 coarse, bits 3-0 fine selection.
// - read-only bits 6-5 give quadrature code advancing per octant.
// - writable bit 3 of ratio register inverts angle direction.
// - read-only bits 2,1,0 flag negative ratio, denominator, numerator.
// - sine constant byte holds sine of plate phase times 255.
// - cosine constant byte holds cosine of plate phase times 255.
`timescale 1ns/1ps
module hall_rotation_config_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register access from the serial slave
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // status from the angle engine
    input wire logic octant_step,
    input wire logic ratio_negative,
    input wire logic denominator_negative,
    input wire logic numerator_negative,
    input wire logic zero_done,
    // wheel wake-up source
    input wire logic channel_zero_touch,
    // controls to the angle engine
    output logic wheel_enable,
    output logic interval_enable,
    output logic zero_request,
    output logic wheel_event_enable,
    output logic interval_event_enable,
    output logic auto_calibration_enable,
    output logic wheel_wake,
    output logic channel_count_filter_enable,
    output logic [1:0] sample_divider_code,
    output logic [4:0] sample_divider,
    output logic [1:0] auto_tuning_mode,
    output logic tuning_adjust_compensation,
    output logic tuning_adjust_fine,
    output logic tuning_adjust_coarse,
    output logic direction_invert,
    output logic [7:0] phase_sine,
    output logic [7:0] phase_cosine,
    // pair a (channels two and three)
    output logic [7:0] pair_a_base_value,
    output logic [10:0] pair_a_count_target,
    output logic [9:0] pair_a_compensation,
    output logic [1:0] pair_a_coarse,
    output logic [3:0] pair_a_fine,
    // pair b (channels four and five)
    output logic [7:0] pair_b_base_value,
    output logic [10:0] pair_b_count_target,
    output logic [9:0] pair_b_compensation,
    output logic [1:0] pair_b_coarse,
    output logic [3:0] pair_b_fine
);
    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] ui_control_reg;
    logic [7:0] sense_control_reg;
    logic [7:0] tuning_reg [2];
    logic [7:0] comp_low_reg [2];
    logic [7:0] mult_reg [2];
    logic invert_reg;
    logic [1:0] octant_reg;
    logic [2:0] sign_reg;
    logic [7:0] sine_reg;
    logic [7:0] cosine_reg;
    logic [7:0] angle_status_value;

    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
        addr_is = (addr == offset);
    endfunction : addr_is

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ui_control_reg <= hall_regs_pkg::rotation_ui_control_reset;
        end else if (reg_write && addr_is(reg_addr, hall_regs_pkg::rotation_ui_control_offset)) begin
            ui_control_reg <= reg_wdata & hall_regs_pkg::rotation_ui_control_mask;
        end else if (zero_done) begin
            ui_control_reg[hall_regs_pkg::zero_wheel_bit] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sense_control_reg <= hall_regs_pkg::hall_sense_control_reset;
        end else if (reg_write && addr_is(reg_addr, hall_regs_pkg::hall_sense_control_offset)) begin
            sense_control_reg <= reg_wdata & hall_regs_pkg::hall_sense_control_mask;
        end
    end

    // ----------------------------------------------------------------
    // per-pair tuning registers
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pair
            localparam logic [7:0] p_off = 8'(p);
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    tuning_reg[p] <= hall_regs_pkg::tuning_settings_reset;
                    comp_low_reg[p] <= hall_regs_pkg::zero_reset;
                    mult_reg[p] <= hall_regs_pkg::zero_reset;
                end else if (reg_write) begin
                    if (addr_is(reg_addr, hall_regs_pkg::pair_a_tuning_settings_offset + p_off)) begin
                        tuning_reg[p] <= reg_wdata;
                    end
                    if (addr_is(reg_addr, hall_regs_pkg::pair_a_compensation_low_offset + p_off)) begin
                        comp_low_reg[p] <= reg_wdata;
                    end
                    if (addr_is(reg_addr, hall_regs_pkg::pair_a_multipliers_offset + p_off)) begin
                        mult_reg[p] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // angle status and phase constants
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            invert_reg <= 1'b0;
        end else if (reg_write && addr_is(reg_addr, hall_regs_pkg::angle_sign_status_offset)) begin
            invert_reg <= reg_wdata[hall_regs_pkg::direction_invert_bit];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            octant_reg <= 2'h0;
        end else if (octant_step) begin
            octant_reg <= octant_reg + 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sign_reg <= 3'h0;
        end else begin
            sign_reg <= {ratio_negative, denominator_negative, numerator_negative};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sine_reg <= hall_regs_pkg::zero_reset;
            cosine_reg <= hall_regs_pkg::zero_reset;
        end else if (reg_write) begin
            if (addr_is(reg_addr, hall_regs_pkg::phase_sine_constant_offset)) begin
                sine_reg <= reg_wdata;
            end
            if (addr_is(reg_addr, hall_regs_pkg::phase_cosine_constant_offset)) begin
                cosine_reg <= reg_wdata;
            end
        end
    end

    assign angle_status_value = {1'b0, octant_reg, 1'b0, invert_reg, sign_reg};

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else if (reg_read) begin
            reg_hit <= 1'b1;
            case (reg_addr)
                hall_regs_pkg::rotation_ui_control_offset: reg_rdata <= ui_control_reg;
                hall_regs_pkg::hall_sense_control_offset: reg_rdata <= sense_control_reg;
                hall_regs_pkg::pair_a_tuning_settings_offset: reg_rdata <= tuning_reg[0];
                hall_regs_pkg::pair_b_tuning_settings_offset: reg_rdata <= tuning_reg[1];
                hall_regs_pkg::pair_a_compensation_low_offset: reg_rdata <= comp_low_reg[0];
                hall_regs_pkg::pair_b_compensation_low_offset: reg_rdata <= comp_low_reg[1];
                hall_regs_pkg::pair_a_multipliers_offset: reg_rdata <= mult_reg[0];
                hall_regs_pkg::pair_b_multipliers_offset: reg_rdata <= mult_reg[1];
                hall_regs_pkg::angle_sign_status_offset: reg_rdata <= angle_status_value;
                hall_regs_pkg::phase_sine_constant_offset: reg_rdata <= sine_reg;
                hall_regs_pkg::phase_cosine_constant_offset: reg_rdata <= cosine_reg;
                default: begin
                    reg_rdata <= 8'h00;
                    reg_hit <= 1'b0;
                end
            endcase
        end else begin
            reg_hit <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // decoded controls
    // ----------------------------------------------------------------
    assign wheel_enable = ~ui_control_reg[hall_regs_pkg::wheel_disable_bit];
    assign interval_enable = ~ui_control_reg[hall_regs_pkg::interval_disable_bit];
    assign zero_request = ui_control_reg[hall_regs_pkg::zero_wheel_bit];
    assign wheel_event_enable = ~ui_control_reg[hall_regs_pkg::wheel_event_mask_bit];
    assign interval_event_enable = ~ui_control_reg[hall_regs_pkg::interval_event_mask_bit];
    assign auto_calibration_enable = ui_control_reg[hall_regs_pkg::auto_calibration_bit];
    assign wheel_wake = ui_control_reg[hall_regs_pkg::wheel_wakeup_bit] & channel_zero_touch;
    assign channel_count_filter_enable = sense_control_reg[hall_regs_pkg::channel_count_filter_bit];
    assign sample_divider_code = sense_control_reg[5:4];
    assign sample_divider = 5'h02 << sense_control_reg[5:4];
    assign auto_tuning_mode = sense_control_reg[1:0];
    assign tuning_adjust_compensation = (auto_tuning_mode != hall_regs_pkg::tuning_off_type_v);
    assign tuning_adjust_fine = auto_tuning_mode[1];
    assign tuning_adjust_coarse = (auto_tuning_mode == hall_regs_pkg::tuning_full_type_v);
    assign direction_invert = invert_reg;
    assign phase_sine = sine_reg;
    assign phase_cosine = cosine_reg;

    // ----------------------------------------------------------------
    // pair decoders
    // ----------------------------------------------------------------
    pair_cfg_if pair_a_cfg ();
    pair_cfg_if pair_b_cfg ();

    pair_tuning_decode u_pair_a (
        .tuning_settings(tuning_reg[0]),
        .compensation_low(comp_low_reg[0]),
        .multipliers(mult_reg[0]),
        .cfg(pair_a_cfg.source)
    );

    pair_tuning_decode u_pair_b (
        .tuning_settings(tuning_reg[1]),
        .compensation_low(comp_low_reg[1]),
        .multipliers(mult_reg[1]),
        .cfg(pair_b_cfg.source)
    );

    assign pair_a_base_value = pair_a_cfg.tuning_base_value;
    assign pair_a_count_target = pair_a_cfg.count_target;
    assign pair_a_compensation = pair_a_cfg.compensation;
    assign pair_a_coarse = pair_a_cfg.coarse_multiplier;
    assign pair_a_fine = pair_a_cfg.fine_multiplier;
    assign pair_b_base_value = pair_b_cfg.tuning_base_value;
    assign pair_b_count_target = pair_b_cfg.count_target;
    assign pair_b_compensation = pair_b_cfg.compensation;
    assign pair_b_coarse = pair_b_cfg.coarse_multiplier;
    assign pair_b_fine = pair_b_cfg.fine_multiplier;
endmodule : hall_rotation_config_regs

// ==== tb/hall_rotation_config_regs_properties.sv ====
// checker: port-level properties of the hall rotation register bank
// assumes: bound to hall_rotation_config_regs, one clock domain
`timescale 1ns/1ps
module hall_regs_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    // engine side
    input wire logic zero_done,
    input wire logic channel_zero_touch,
    input wire logic wheel_enable,
    input wire logic zero_request,
    input wire logic wheel_wake,
    input wire logic [1:0] sample_divider_code,
    input wire logic [4:0] sample_divider,
    input wire logic [1:0] auto_tuning_mode,
    input wire logic tuning_adjust_compensation,
    input wire logic tuning_adjust_fine,
    input wire logic tuning_adjust_coarse,
    input wire logic [10:0] pair_b_count_target,
    input wire logic [9:0] pair_a_compensation
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_wheel_gate_write: assert property (
        reg_write && reg_addr == 8'h70 |=> wheel_enable == !$past(reg_wdata[7]))
        else $error("wheel enable does not follow bit 7");
    a_zero_arm_write: assert property (
        reg_write && reg_addr == 8'h70 |=> zero_request == $past(reg_wdata[5]))
        else $error("zero request does not follow written bit 5");
    a_zero_self_clear: assert property (
        zero_done && !(reg_write && reg_addr == 8'h70) |=> !zero_request)
        else $error("zero request not cleared by zero done");
    a_wake_needs_touch: assert property (
        wheel_wake |-> channel_zero_touch)
        else $error("wheel wake without channel zero touch");
    a_divider_code_map: assert property (
        sample_divider == (sample_divider_code == 2'h0 ? 5'h02 : sample_divider_code == 2'h1 ?
        5'h04 : sample_divider_code == 2'h2 ? 5'h08 : 5'h10))
        else $error("sample divider does not match its code");
    a_tuning_mode_map: assert property (
        tuning_adjust_compensation == (auto_tuning_mode != 2'h0)
        && tuning_adjust_fine == auto_tuning_mode[1]
        && tuning_adjust_coarse == (auto_tuning_mode == 2'h3))
        else $error("tuning adjust flags do not match mode");
    a_target_times_32: assert property (
        reg_write && reg_addr == 8'h73 |=>
        pair_b_count_target == {$past(reg_wdata[5:0]), 5'h00})
        else $error("pair b count target not target times 32");
    a_comp_upper_bits: assert property (
        reg_write && reg_addr == 8'h76 |=> pair_a_compensation[9:8] == $past(reg_wdata[7:6]))
        else $error("pair a compensation upper bits wrong");
    a_unmapped_read_zero: assert property (
        reg_read && (reg_addr < 8'h70 || reg_addr > 8'h7a) |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read not refused");
endmodule : hall_regs_checker
bind hall_rotation_config_regs hall_regs_checker chk (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .zero_done(zero_done),
    .channel_zero_touch(channel_zero_touch), .wheel_enable(wheel_enable),
    .zero_request(zero_request), .wheel_wake(wheel_wake),
    .sample_divider_code(sample_divider_code), .sample_divider(sample_divider),
    .auto_tuning_mode(auto_tuning_mode), .tuning_adjust_compensation(tuning_adjust_compensation),
    .tuning_adjust_fine(tuning_adjust_fine), .tuning_adjust_coarse(tuning_adjust_coarse),
    .pair_b_count_target(pair_b_count_target), .pair_a_compensation(pair_a_compensation));

// ==== tb/hall_host_model.sv ====
// host model: issues register writes and reads to the bank
// assumes: one-cycle strobes, read answer one cycle after the request
`timescale 1ns/1ps
module hall_host_model (
    // clock
    input wire logic core_clk,
    // register access
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit
);
    // the channel mask lives outside this bank
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // idle bus shows inverted values so stale data is never mistaken for a request
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
        @(posedge core_clk);
        #1 {reg_addr, reg_wdata, reg_write} = {~a, ~d, 1'b0};
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge core_clk);
        #1 {reg_addr, reg_read} = {a, 1'b1};
        @(posedge core_clk);
        #1 {reg_addr, reg_read} = {~a, 1'b0};
        d = reg_rdata;
        h = reg_hit;
    endtask : read_reg
endmodule : hall_host_model

// ==== tb/hall_rotation_config_regs_tb_top.sv ====
// testbench: random and directed register traffic checked against a bench model
// assumes: package compiled first; checker bound to the design
`timescale 1ns/1ps
module hall_rotation_config_regs_tb_top;
    logic core_clk, rst, reg_write, reg_read, reg_hit, octant_step, zero_done;
    logic ratio_negative, denominator_negative, numerator_negative, channel_zero_touch;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, phase_sine, phase_cosine;
    logic wheel_enable, interval_enable, zero_request, wheel_event_enable, wheel_wake;
    logic interval_event_enable, auto_calibration_enable, channel_count_filter_enable;
    logic tuning_adjust_compensation, tuning_adjust_fine, tuning_adjust_coarse, direction_invert;
    logic [1:0] sample_divider_code, auto_tuning_mode, pair_a_coarse, pair_b_coarse;
    logic [4:0] sample_divider;
    logic [7:0] pair_a_base_value, pair_b_base_value;
    logic [10:0] pair_a_count_target, pair_b_count_target;
    logic [9:0] pair_a_compensation, pair_b_compensation;
    logic [3:0] pair_a_fine, pair_b_fine;
    logic [7:0] mdl [0:10];
    logic [2:0] sgn;
    int quad, failures, num_checks;

    hall_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
    hall_rotation_config_regs dut (.*);

    function automatic logic [7:0] wmask(input int i);
        case (i)
            0: return hall_regs_pkg::rotation_ui_control_mask;
            1: return hall_regs_pkg::hall_sense_control_mask;
            8: return hall_regs_pkg::angle_status_write_mask;
            default: return 8'hff;
        endcase
    endfunction : wmask
    function automatic logic [7:0] base(input logic [1:0] c);
        logic [7:0] t [0:3];
        t = '{8'h4b, 8'h64, 8'h96, 8'hc8};
        return t[c];
    endfunction : base
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d);
        if (a >= 8'h70 && a <= 8'h7a) mdl[a - 8'h70] = d & wmask(a - 8'h70);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic [7:0] d, e;
        logic h, m;
        host.read_reg(a, d, h);
        m = a >= 8'h70 && a <= 8'h7a;
        e = m ? mdl[a - 8'h70] : 8'h00;
        if (a == 8'h78) e = e | {1'b0, quad[1:0], 2'b00, sgn};
        check("read data", d, e);
        check("read hit", h, m);
    endtask : rd
    task automatic chk_out;
        logic [7:0] u, s;
        u = mdl[0];
        s = mdl[1];
        check("wheel_enable", wheel_enable, !u[7]);
        check("interval_enable", interval_enable, !u[6]);
        check("zero_request", zero_request, u[5]);
        check("wheel_event", wheel_event_enable, !u[4]);
        check("interval_event", interval_event_enable, !u[3]);
        check("auto_calibration", auto_calibration_enable, u[2]);
        check("wheel_wake", wheel_wake, u[0] & channel_zero_touch);
        check("count_filter", channel_count_filter_enable, s[7]);
        check("divider", {sample_divider_code, sample_divider}, {s[5:4], 5'h02 << s[5:4]});
        check("tuning", {auto_tuning_mode, tuning_adjust_compensation, tuning_adjust_fine,
            tuning_adjust_coarse}, {s[1:0], s[1:0] != 2'h0, s[1], s[1:0] == 2'h3});
        check("direction", direction_invert, mdl[8][3]);
        check("sine", phase_sine, mdl[9]);
        check("cosine", phase_cosine, mdl[10]);
        check("a_base", pair_a_base_value, base(mdl[2][7:6]));
        check("a_target", pair_a_count_target, {mdl[2][5:0], 5'h00});
        check("b_tuning", {pair_b_base_value, pair_b_count_target},
            {base(mdl[3][7:6]), mdl[3][5:0], 5'h00});
        check("a_comp", pair_a_compensation, {mdl[6][7:6], mdl[4]});
        check("b_comp", pair_b_compensation, {mdl[7][7:6], mdl[5]});
        check("a_mult", {pair_a_coarse, pair_a_fine}, mdl[6][5:0]);
        check("b_mult", {pair_b_coarse, pair_b_fine}, mdl[7][5:0]);
    endtask : chk_out
    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #2000000;
        failures++;
        stop_test;
    end
    initial begin
        {rst, octant_step, zero_done, channel_zero_touch} = 4'h8;
        {ratio_negative, denominator_negative, numerator_negative} = 3'h0;
        {failures, num_checks, quad, sgn} = '0;
        mdl = '{8'h0c, 8'h03, 8'h73, 8'h73, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        void'($urandom(32'h972641a8));
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 11; i++) rd(8'h70 + i[7:0]);
        chk_out;
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h71, {2'b10, i[1:0], 2'b11, i[1:0]});
            wr(8'h72, {i[1:0], 6'h3f});
            chk_out;
        end
        // calibrated plate phase handed to the device
        wr(8'h79, 8'hb4);
        wr(8'h7a, 8'hb4);
        repeat (80) begin
            wr(8'h6e + 8'($urandom_range(0, 14)), 8'($urandom));
            channel_zero_touch = 1'($urandom);
            #1 chk_out;
            rd(8'h6e + 8'($urandom_range(0, 14)));
        end
        $display("test random traffic done");
        wr(8'h70, 8'h21);
        channel_zero_touch = 1'b1;
        #1 chk_out;
        @(posedge core_clk);
        #1 zero_done = 1'b1;
        @(posedge core_clk);
        #1 zero_done = 1'b0;
        mdl[0][5] = 1'b0;
        chk_out;
        // host write and zero done on one edge: the write re-arms the request
        wr(8'h70, 8'h20);
        fork
            wr(8'h70, 8'h24);
            begin
                @(posedge core_clk);
                #1 zero_done = 1'b1;
                @(posedge core_clk);
                #1 zero_done = 1'b0;
            end
        join
        chk_out;
        $display("test zero and wake done");
        {ratio_negative, numerator_negative} = 2'b11;
        sgn = 3'b101;
        repeat (5) begin
            @(posedge core_clk);
            #1 octant_step = 1'b1;
            @(posedge core_clk);
            #1 octant_step = 1'b0;
            quad++;
        end
        rd(8'h78);
        wr(8'h78, 8'hff);
        rd(8'h78);
        chk_out;
        $display("test angle status done");
        stop_test;
    end
endmodule : hall_rotation_config_regs_tb_top
